// ### shared/jmex_regs.vh
`ifndef JMEX_REGS_VH
`define JMEX_REGS_VH
// operation selects presented by the core decoder
`define JMEX_OP_NONE 3'h0
`define JMEX_OP_JUMP 3'h1
`define JMEX_OP_LDM 3'h2
`define JMEX_OP_LDI 3'h3
`define JMEX_OP_STM 3'h4
`define JMEX_OP_INC 3'h5
// reset values
`define JMEX_ACC_RST 8'h00
`define JMEX_PC_RST 13'h0000
`define JMEX_ZF_RST 1'b0
// execute states
`define JMEX_ST_EXEC 1'b0
`define JMEX_ST_DUMMY 1'b1
`endif

// ### hdl/jmex_alu.v
`include "jmex_regs.vh"
module jmex_alu #(
  parameter DW = 8
) (
  input wire [2:0] op,
  input wire [DW-1:0] mem_rdata,
  input wire [DW-1:0] imm,
  input wire [DW-1:0] acc,
  output reg [DW-1:0] acc_next,
  output reg acc_load,
  output reg zf_load,
  output wire zf_value
);
  wire [DW-1:0] inc_value;
  assign inc_value = mem_rdata + {{(DW-1){1'b0}}, 1'b1};
  assign zf_value = (acc_next == {DW{1'b0}});
  always @* begin
    acc_next = acc;
    acc_load = 1'b0;
    zf_load = 1'b0;
    case (op)
      `JMEX_OP_LDM: begin
        acc_next = mem_rdata;
        acc_load = 1'b1;
      end
      `JMEX_OP_LDI: begin
        acc_next = imm;
        acc_load = 1'b1;
      end
      `JMEX_OP_INC: begin
        acc_next = inc_value;
        acc_load = 1'b1;
        zf_load = 1'b1;
      end
      default: begin
        acc_next = acc;
      end
    endcase
  end
endmodule // jmex_alu

// ### hdl/jmex_exec.v
// Behaviour
// - a jump loads the pc with its target and changes no flag.
// - a jump takes two cycles, the second being a dummy cycle.
// - load from memory copies the byte into acc, flags kept.
// - load immediate puts the literal into acc, flags kept.
// - store writes acc into memory, acc and flags kept.
// - increment puts memory byte plus one in acc, only zero flag set.

`include "jmex_regs.vh"
module jmex_exec #(
  parameter DW = 8,
  parameter AW = 13,
  parameter MW = 8
) (
  input wire clk,
  input wire srst,
  input wire instr_valid,
  input wire [2:0] instr_op,
  input wire [AW-1:0] instr_addr,
  input wire [MW-1:0] instr_mem_addr,
  input wire [DW-1:0] instr_imm,
  input wire [DW-1:0] mem_rdata,
  output wire [MW-1:0] mem_addr,
  output reg mem_we,
  output reg [DW-1:0] mem_wdata,
  output reg [AW-1:0] pc_reg,
  output wire fetch_ready,
  output wire dummy_cycle,
  output reg [DW-1:0] accumulator_reg,
  output reg zero_flag_reg
);
  ////////////////////////////////////////////////////////////////////////
  // state codes and next values
  localparam ST_EXEC = 1'b0;
  localparam ST_DUMMY = 1'b1;

  reg state_reg;
  reg state_next;
  reg [AW-1:0] pc_next;
  reg [DW-1:0] accumulator_next;
  reg zero_flag_next;
  reg mem_we_next;
  reg [DW-1:0] mem_wdata_next;

  wire take;
  wire [2:0] op_eff;
  wire [DW-1:0] acc_next;
  wire acc_load;
  wire zf_load;
  wire zf_value;
  wire [AW-1:0] pc_inc;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers, shared by sequencing, pc and store logic

  function op_is_jump;
    input [2:0] op;
    begin
      op_is_jump = (op == `JMEX_OP_JUMP);
    end
  endfunction

  function op_is_store;
    input [2:0] op;
    begin
      op_is_store = (op == `JMEX_OP_STM);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // handshake with the core decoder

  // decoder must hold off while the dummy cycle runs
  assign fetch_ready = (state_reg == ST_EXEC);
  assign dummy_cycle = (state_reg == ST_DUMMY);
  assign take = instr_valid && fetch_ready;
  // gating here makes every later decode see no op in the dummy cycle
  assign op_eff = take ? instr_op : `JMEX_OP_NONE;

  ////////////////////////////////////////////////////////////////////////
  // data memory read path and pc step

  // read address is combinational so the byte returns in the same cycle
  assign mem_addr = instr_mem_addr;
  assign pc_inc = pc_reg + {{(AW-1){1'b0}}, 1'b1};

  jmex_alu #(
    .DW(DW)
  ) u_alu (
    .op(op_eff),
    .mem_rdata(mem_rdata),
    .imm(instr_imm),
    .acc(accumulator_reg),
    .acc_next(acc_next),
    .acc_load(acc_load),
    .zf_load(zf_load),
    .zf_value(zf_value)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencing: a jump parks the core for one dummy cycle

  always @* begin
    state_next = state_reg;

    case (state_reg)
      ST_EXEC: begin
        if (op_is_jump(op_eff)) begin
          state_next = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        // whatever the decoder offers now is refused
        state_next = ST_EXEC;
      end
      default: begin
        state_next = ST_EXEC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter

  // a refused request neither moves the pc nor reaches the alu
  always @* begin
    pc_next = pc_reg;

    if (op_is_jump(op_eff)) begin
      pc_next = instr_addr;
    end else if (take) begin
      pc_next = pc_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator and zero flag

  always @* begin
    accumulator_next = accumulator_reg;
    zero_flag_next = zero_flag_reg;

    if (acc_load) begin
      accumulator_next = acc_next;
    end
    // only increment touches the flag; moves and jumps leave it
    if (zf_load) begin
      zero_flag_next = zf_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // store port

  // the write lands a cycle after the store is taken, so the memory
  // side has to keep the address it saw at the store's edge
  // back-to-back stores keep the strobe high for both cycles
  always @* begin
    mem_we_next = 1'b0;
    mem_wdata_next = mem_wdata;

    if (op_is_store(op_eff)) begin
      mem_we_next = 1'b1;
      mem_wdata_next = accumulator_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing and program counter registers

  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      pc_reg <= `JMEX_PC_RST;
    end else begin
      pc_reg <= pc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // datapath registers

  always @(posedge clk) begin
    if (srst) begin
      accumulator_reg <= `JMEX_ACC_RST;
    end else begin
      accumulator_reg <= accumulator_next;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      zero_flag_reg <= `JMEX_ZF_RST;
    end else begin
      zero_flag_reg <= zero_flag_next;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      mem_we <= 1'b0;
    end else begin
      mem_we <= mem_we_next;
    end
  end

  // data holds between stores; only the strobe pulses
  always @(posedge clk) begin
    if (srst) begin
      mem_wdata <= {DW{1'b0}};
    end else begin
      mem_wdata <= mem_wdata_next;
    end
  end
endmodule // jmex_exec

// ### dv/jmex_props.sv
`include "jmex_regs.vh"
module jmex_props (
  input wire clk,
  input wire srst,
  input wire instr_valid,
  input wire fetch_ready,
  input wire [2:0] instr_op,
  input wire [12:0] instr_addr,
  input wire [12:0] pc_reg,
  input wire [7:0] instr_imm,
  input wire [7:0] mem_rdata,
  input wire [7:0] accumulator_reg,
  input wire [7:0] mem_wdata,
  input wire mem_we,
  input wire dummy_cycle,
  input wire zero_flag_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire tk = instr_valid && fetch_ready;
  wire [2:0] o = instr_op;
  sequence jump_taken; tk && o == `JMEX_OP_JUMP; endsequence
  a_jump_loads_pc: assert property (jump_taken |=>
    pc_reg == $past(instr_addr) && $stable(zero_flag_reg)) else $error("pc");
  sequence dummy_then_fetch;
    dummy_cycle && !fetch_ready ##1 fetch_ready;
  endsequence
  a_jump_one_dummy: assert property (jump_taken |=> dummy_then_fetch)
    else $error("dummy");
  a_dummy_refuses: assert property (dummy_cycle |=>
    $stable(pc_reg) && $stable(accumulator_reg)) else $error("refuse");
  a_ldm_copies: assert property (tk && o == `JMEX_OP_LDM |=>
    accumulator_reg == $past(mem_rdata) && $stable(zero_flag_reg))
    else $error("ldm");
  a_ldi_loads: assert property (tk && o == `JMEX_OP_LDI |=>
    accumulator_reg == $past(instr_imm) && $stable(zero_flag_reg))
    else $error("ldi");
  a_store_writes: assert property (tk && o == `JMEX_OP_STM |=>
    mem_we && mem_wdata == $past(accumulator_reg) && $stable(accumulator_reg))
    else $error("stm");
  a_inc_result: assert property (tk && o == `JMEX_OP_INC |=>
    accumulator_reg == $past(mem_rdata) + 8'h01 &&
    zero_flag_reg == (accumulator_reg == 8'h00)) else $error("inc");
endmodule // jmex_props

// ### dv/jmex_mem_model.sv
module jmex_mem_model (
  input wire clk,
  input wire mem_we,
  input wire [7:0] mem_addr,
  input wire [7:0] mem_wdata,
  output wire [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] mem [0:255];
  reg [7:0] wa_reg;
  integer i;
  initial for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0];
  assign mem_rdata = mem[mem_addr];
  // address follows the live bus, so hold the one seen at the store edge
  always @(posedge clk) begin
    wa_reg <= mem_addr;
    if (mem_we) mem[wa_reg] <= mem_wdata;
  end
endmodule // jmex_mem_model

// ### dv/tb_top.sv
`include "jmex_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk = 0, srst = 1, instr_valid = 0;
  reg [2:0] instr_op = 0;
  reg [12:0] instr_addr = 0;
  reg [7:0] instr_mem_addr = 0, instr_imm = 0;
  wire [7:0] mem_addr, mem_rdata, mem_wdata, accumulator_reg;
  wire [12:0] pc_reg;
  wire mem_we, fetch_ready, dummy_cycle, zero_flag_reg;
  integer errors = 0, n_compared = 0;
  jmex_exec dut (
    .clk(clk),
    .srst(srst),
    .instr_valid(instr_valid),
    .instr_op(instr_op),
    .instr_addr(instr_addr),
    .instr_mem_addr(instr_mem_addr),
    .instr_imm(instr_imm),
    .mem_rdata(mem_rdata),
    .mem_addr(mem_addr),
    .mem_we(mem_we),
    .mem_wdata(mem_wdata),
    .pc_reg(pc_reg),
    .fetch_ready(fetch_ready),
    .dummy_cycle(dummy_cycle),
    .accumulator_reg(accumulator_reg),
    .zero_flag_reg(zero_flag_reg)
  );
  jmex_mem_model mdl (
    .clk(clk),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata)
  );
  initial forever #2 clk = ~clk;
  task chk(input string nm, input [12:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task op(input [2:0] o, input [12:0] a, input [7:0] d);
    @(negedge clk);
    instr_valid = 1;
    instr_op = o;
    instr_addr = a;
    instr_mem_addr = d;
    instr_imm = d;
    // hold the request until an edge on which the core is ready
    while (!fetch_ready) @(negedge clk);
    @(negedge clk);
    instr_valid = 0;
  endtask
  task t_moves;
    op(`JMEX_OP_LDI, 0, 8'hff);
    chk("acc", accumulator_reg, 13'hff);
    op(`JMEX_OP_INC, 0, 8'h34);
    chk("acc", accumulator_reg, 13'h35);
    chk("zf", zero_flag_reg, 13'h0);
    op(`JMEX_OP_INC, 0, 8'hff);
    chk("acc", accumulator_reg, 13'h0);
    chk("zf", zero_flag_reg, 13'h1);
    op(`JMEX_OP_LDM, 0, 8'h12);
    chk("acc", accumulator_reg, 13'h12);
    chk("zf", zero_flag_reg, 13'h1);
    op(`JMEX_OP_STM, 0, 8'h34);
    chk("acc", accumulator_reg, 13'h12);
    chk("we", mem_we, 13'h1);
    chk("wdata", mem_wdata, 13'h12);
    chk("addr", mem_addr, 13'h34);
    op(`JMEX_OP_LDI, 0, 8'h77);
    chk("we", mem_we, 13'h0);
    chk("zf", zero_flag_reg, 13'h1);
    op(`JMEX_OP_LDM, 0, 8'h34);
    chk("mem", accumulator_reg, 13'h12);
    op(`JMEX_OP_LDM, 0, 8'hff);
    chk("mem", accumulator_reg, 13'hff);
    $display("moves done");
  endtask
  task t_jump;
    @(negedge clk);
    instr_valid = 1'b1;
    instr_op = `JMEX_OP_JUMP;
    instr_addr = 13'h1abc;
    @(negedge clk);
    chk("pc", pc_reg, 13'h1abc);
    chk("zf", zero_flag_reg, 13'h1);
    chk("dummy", dummy_cycle, 13'h1);
    chk("ready", fetch_ready, 13'h0);
    // offered during the dummy cycle: refused once, taken on the next edge
    instr_op = `JMEX_OP_LDI;
    instr_imm = 8'h55;
    @(negedge clk);
    chk("acc", accumulator_reg, 13'hff);
    chk("pc", pc_reg, 13'h1abc);
    chk("dummy", dummy_cycle, 13'h0);
    @(negedge clk);
    instr_valid = 1'b0;
    chk("acc", accumulator_reg, 13'h55);
    chk("pc", pc_reg, 13'h1abd);
    $display("jump done");
  endtask
  task t_reset;
    @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    chk("pc", pc_reg, 13'h0);
    chk("acc", accumulator_reg, 13'h0);
    chk("zf", zero_flag_reg, 13'h0);
    chk("we", mem_we, 13'h0);
    chk("ready", fetch_ready, 13'h1);
    srst = 1'b0;
    op(`JMEX_OP_LDI, 0, 8'h5a);
    chk("acc", accumulator_reg, 13'h5a);
    chk("pc", pc_reg, 13'h1);
    $display("reset done");
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    srst = 0;
    t_moves;
    t_jump;
    t_reset;
    give_verdict;
  end
  // whole run is about 31 cycles; the limit allows over eight times that
  initial begin
    #1000;
    errors++;
    give_verdict;
  end
endmodule // tb_top
bind jmex_exec jmex_props u_props (
  .clk(clk),
  .srst(srst),
  .instr_valid(instr_valid),
  .fetch_ready(fetch_ready),
  .instr_op(instr_op),
  .instr_addr(instr_addr),
  .pc_reg(pc_reg),
  .instr_imm(instr_imm),
  .mem_rdata(mem_rdata),
  .accumulator_reg(accumulator_reg),
  .mem_wdata(mem_wdata),
  .mem_we(mem_we),
  .dummy_cycle(dummy_cycle),
  .zero_flag_reg(zero_flag_reg)
);
